// >>> rtl/tes_map.svh
`ifndef TES_MAP_SVH
`define TES_MAP_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define TES_ADDR_CTRL   8'h00
`define TES_ADDR_TDLY   8'h04
`define TES_ADDR_EXPO   8'h08
`define TES_ADDR_LINES  8'h0C
`define TES_ADDR_POST   8'h10
`define TES_ADDR_STAT   8'h14
`define TES_ADDR_FCNT   8'h18

// ----------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------
`define TES_CTRL_EN     0
`define TES_CTRL_TRIG   1
`define TES_CTRL_SWTRG  2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define TES_RST_TDLY    24'h000000
`define TES_RST_EXPO    12'h004
`define TES_RST_LINES   12'h010
`define TES_RST_POST    24'h0000C8

// ----------------------------------------------------------------
// sensor geometry and exposure limits
// ----------------------------------------------------------------
`define TES_LINE_PIX    2624
`define TES_EXP_MIN     12'h001

// ----------------------------------------------------------------
// timing, in ns, and derived cycle counts
// ----------------------------------------------------------------
`define TES_CLK_NS      4
`define TES_TRG_STB_NS  500
`define TES_SNS_STB_NS  2000
`define TES_EXP_ACT_NS  1500
`define TES_TRG_STB_CYC (`TES_TRG_STB_NS / `TES_CLK_NS)
`define TES_SNS_STB_CYC (`TES_SNS_STB_NS / `TES_CLK_NS)
`define TES_EXP_ACT_CYC (`TES_EXP_ACT_NS / `TES_CLK_NS)
`define TES_OUT_STAGE   1

`endif

// >>> rtl/tes_pkg.sv
package tes_pkg;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TES_IDLE  = 2'b00,
    TES_DELAY = 2'b01,
    TES_SCAN  = 2'b10,
    TES_POST  = 2'b11
  } tes_state_t;

  // ----------------------------------------------------------------
  // sensor control bundle
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        reset_all;
    logic        row_rst;
    logic [11:0] rst_row;
    logic        read_en;
    logic [11:0] read_row;
    logic [11:0] col;
  } tes_sens_t;

endpackage

// >>> rtl/tes_lvl_delay.sv
`timescale 1ns/10ps
module tes_lvl_delay #(
  parameter int DLY = 8,
  parameter int CW  = 10
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic din,
  output logic      dout
);

  // ----------------------------------------------------------------
  // edge replay: each change of din reaches dout DLY cycles later;
  // a change arriving before the previous one is replayed wins
  // ----------------------------------------------------------------
  logic [CW-1:0] cnt;
  logic          pend;
  logic          val;
  wire           changed = (din != val);
  wire           expire  = pend && (cnt == '0);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt  <= '0;
      pend <= 1'b0;
      val  <= 1'b0;
      dout <= 1'b0;
    end else if (changed) begin
      val  <= din;
      // the change is seen one edge after din moved, so that edge is counted too
      cnt  <= CW'(DLY - 2);
      pend <= 1'b1;
    end else if (expire) begin
      dout <= val;
      pend <= 1'b0;
    end else if (pend) begin
      cnt <= cnt - 1'b1;
    end
  end

  a_dly_count : assert property (@(posedge clk) disable iff (!rst_n)
    pend && !changed && cnt != '0 |=> cnt == $past(cnt) - 1'b1)
    else $error("delay counter did not step");

endmodule // tes_lvl_delay

// >>> rtl/tes_sequencer.sv
// ----------------------------------------------------------------
// Overview of operation
// RULE1 - triggered mode keeps the sensor idle until a trigger, then exposes and reads
// RULE2 - an accepted trigger waits the programmed trigger delay before exposure
// RULE3 - trigger source spaces triggers by exposure plus readout plus post timeout
// RULE4 - after readout a post-image timeout passes before the next exposure
// RULE5 - strobe output follows the trigger input after about 0.5 us
// RULE6 - sensor internal strobe reaches the strobe output after about 2 us
// RULE7 - exposure-active output rises about 1.5 us after exposure starts
// RULE8 - every line is read in full, 2624 pixels, whatever the region width
// RULE9 - free-run uses rolling shutter, triggered starts use global reset release
// RULE10 - rolling shutter starts each row one line time after the previous row
// RULE11 - global reset resets all rows; later rows integrate one line longer
// RULE12 - rolling-shutter flash starts after all rows open, ends before first closes
// RULE13 - global-reset flash may fire at exposure start with no delay
// RULE14 - exposure is whole row times with an enforced minimum
// RULE15 - triggers arriving while a frame sequence runs are dropped, not queued
// ----------------------------------------------------------------
`timescale 1ns/10ps
`include "tes_map.svh"
module tes_sequencer
  import tes_pkg::*;
#(
  parameter int LINE_PIX = `TES_LINE_PIX
) (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  input  wire logic        hw_trig,
  input  wire logic        sens_strobe,
  output tes_sens_t        sens,
  output logic             strobe_out,
  output logic             exp_active
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic        enable;
  logic        mode_trig;
  logic [23:0] trig_delay;
  logic [11:0] exp_rows;
  logic [11:0] lines;
  logic [23:0] post_cyc;
  logic [15:0] frame_cnt;

  wire wr_ctrl  = wr && (addr == `TES_ADDR_CTRL);
  wire wr_tdly  = wr && (addr == `TES_ADDR_TDLY);
  wire wr_expo  = wr && (addr == `TES_ADDR_EXPO);
  wire wr_lines = wr && (addr == `TES_ADDR_LINES);
  wire wr_post  = wr && (addr == `TES_ADDR_POST);
  wire sw_trig  = wr_ctrl && wdata[`TES_CTRL_SWTRG];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable     <= 1'b0;
      mode_trig  <= 1'b0;
      trig_delay <= `TES_RST_TDLY;
      exp_rows   <= `TES_RST_EXPO;
      lines      <= `TES_RST_LINES;
      post_cyc   <= `TES_RST_POST;
    end else begin
      if (wr_ctrl) begin
        enable    <= wdata[`TES_CTRL_EN];
        mode_trig <= wdata[`TES_CTRL_TRIG];
      end
      if (wr_tdly)
        trig_delay <= wdata[23:0];
      if (wr_expo)
        exp_rows <= wdata[11:0];
      if (wr_lines)
        lines <= wdata[11:0];
      if (wr_post)
        post_cyc <= wdata[23:0];
    end
  end

  // ----------------------------------------------------------------
  // trigger detection
  // ----------------------------------------------------------------
  logic trig_prev;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      trig_prev <= 1'b0;
    else
      trig_prev <= hw_trig;
  end

  wire hw_rise  = hw_trig && !trig_prev;
  wire trig_evt = enable && mode_trig && (hw_rise || sw_trig);

  // ----------------------------------------------------------------
  // frame sequencer
  // ----------------------------------------------------------------
  tes_state_t  state;
  tes_state_t  next_state;
  logic [23:0] cnt;
  logic [23:0] next_cnt;
  logic [11:0] col;
  logic [12:0] k;
  logic        glob;
  logic [11:0] exp_eff;
  logic [11:0] lines_l;

  wire [11:0] exp_clamp = (exp_rows < `TES_EXP_MIN) ? `TES_EXP_MIN : exp_rows; // see RULE14
  wire        col_last  = (col == 12'(LINE_PIX - 1));                          // see RULE8
  wire [12:0] scan_len  = 13'(exp_eff) + 13'(lines_l);
  wire        scan_end  = col_last && (k == scan_len - 13'h0001);
  wire        cnt_zero  = (cnt == 24'h000000);
  wire        start     = (state != TES_SCAN) && (next_state == TES_SCAN);

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      TES_IDLE: begin
        if (trig_evt) begin // see RULE1, RULE15
          next_state = TES_DELAY;
          next_cnt   = trig_delay; // see RULE2
        end else if (enable && !mode_trig) begin
          next_state = TES_SCAN;
        end
      end
      TES_DELAY: begin
        if (cnt_zero)
          next_state = TES_SCAN; // see RULE2
        else
          next_cnt = cnt - 24'h000001;
      end
      TES_SCAN: begin
        if (scan_end) begin
          next_state = TES_POST; // see RULE4
          next_cnt   = post_cyc;
        end
      end
      TES_POST: begin
        if (cnt_zero)
          next_state = TES_IDLE;
        else
          next_cnt = cnt - 24'h000001; // see RULE4
      end
      default: begin
        next_state = TES_IDLE;
        next_cnt   = 24'h000000;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= TES_IDLE;
      cnt   <= 24'h000000;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // frame parameters are frozen for the whole scan
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      glob    <= 1'b0;
      exp_eff <= `TES_EXP_MIN;
      lines_l <= `TES_RST_LINES;
    end else if (start) begin
      glob    <= mode_trig;  // see RULE9
      exp_eff <= exp_clamp;  // see RULE14
      lines_l <= lines;
    end
  end

  // line timer: one line time is a full sensor line of pixels
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      col <= 12'h000;
      k   <= 13'h0000;
    end else if (state != TES_SCAN) begin
      col <= 12'h000;
      k   <= 13'h0000;
    end else if (col_last) begin
      col <= 12'h000; // see RULE8
      k   <= k + 13'h0001;
    end else begin
      col <= col + 12'h001;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      frame_cnt <= 16'h0000;
    else if (state == TES_SCAN && scan_end)
      frame_cnt <= frame_cnt + 16'h0001;
  end

  // ----------------------------------------------------------------
  // sensor row control
  // ----------------------------------------------------------------
  wire        scan       = (state == TES_SCAN);
  wire        line_start = scan && (col == 12'h000);
  wire [12:0] rd_idx     = k - 13'(exp_eff);
  wire        in_read    = scan && (k >= 13'(exp_eff)) && (rd_idx < 13'(lines_l));
  wire        exposing   = scan && (k < 13'(exp_eff));
  tes_sens_t  next_sens;

  always_comb begin
    next_sens           = '0;
    next_sens.reset_all = line_start && glob && (k == 13'h0000);         // see RULE11
    next_sens.row_rst   = line_start && !glob && (k < 13'(lines_l));     // see RULE10
    next_sens.rst_row   = k[11:0];
    next_sens.read_en   = in_read;                                        // see RULE10
    next_sens.read_row  = rd_idx[11:0];                                   // see RULE11
    next_sens.col       = col;                                            // see RULE8
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      sens <= '0;
    else
      sens <= next_sens;
  end

  // ----------------------------------------------------------------
  // digital outputs
  // ----------------------------------------------------------------
  logic trg_stb;
  logic sns_stb;
  logic exp_dly;

  tes_lvl_delay #(
    .DLY (`TES_TRG_STB_CYC - `TES_OUT_STAGE),
    .CW  (10)
  ) u_trg_stb ( // see RULE5
    .clk   (ref_clk),
    .rst_n (rst_n),
    .din   (hw_trig),
    .dout  (trg_stb)
  );

  tes_lvl_delay #(
    .DLY (`TES_SNS_STB_CYC - `TES_OUT_STAGE),
    .CW  (10)
  ) u_sns_stb ( // see RULE6
    .clk   (ref_clk),
    .rst_n (rst_n),
    .din   (sens_strobe),
    .dout  (sns_stb)
  );

  tes_lvl_delay #(
    .DLY (`TES_EXP_ACT_CYC - `TES_OUT_STAGE),
    .CW  (10)
  ) u_exp_act ( // see RULE7
    .clk   (ref_clk),
    .rst_n (rst_n),
    .din   (exposing),
    .dout  (exp_dly)
  );

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      strobe_out <= 1'b0;
      exp_active <= 1'b0;
    end else begin
      strobe_out <= trg_stb || sns_stb; // see RULE5
      exp_active <= exp_dly;            // see RULE7
    end
  end

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  wire [31:0] stat_word = {28'h0000000, glob, (state != TES_IDLE), state};
  wire [31:0] rmux =
    (addr == `TES_ADDR_CTRL)  ? {30'h00000000, mode_trig, enable} :
    (addr == `TES_ADDR_TDLY)  ? {8'h00, trig_delay} :
    (addr == `TES_ADDR_EXPO)  ? {20'h00000, exp_rows} :
    (addr == `TES_ADDR_LINES) ? {20'h00000, lines} :
    (addr == `TES_ADDR_POST)  ? {8'h00, post_cyc} :
    (addr == `TES_ADDR_STAT)  ? stat_word :
    (addr == `TES_ADDR_FCNT)  ? {16'h0000, frame_cnt} : 32'h00000000;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      rdata <= 32'h00000000;
    else
      rdata <= rd ? rmux : 32'h00000000;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_accept;
    state == TES_IDLE && trig_evt;
  endsequence

  sequence s_delay_entered;
    state == TES_DELAY && cnt == $past(trig_delay);
  endsequence

  a_idle_hold : assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE1
    state == TES_IDLE && mode_trig && !trig_evt |=> state == TES_IDLE)
    else $error("triggered mode left idle without a trigger");

  a_delay_load : assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE2
    s_accept |=> s_delay_entered)
    else $error("trigger delay not loaded on accept");

  a_delay_end : assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE2
    state == TES_DELAY && cnt == 24'h000002 |=> state == TES_DELAY ##2 state == TES_SCAN)
    else $error("trigger delay expired at the wrong cycle");

  a_post_wait : assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE4
    state == TES_POST && !cnt_zero |=> state == TES_POST && cnt == $past(cnt) - 24'h000001)
    else $error("post-image timeout cut short");

  a_line_step : assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE8
    scan && !col_last && !scan_end |=> col == $past(col) + 12'h001 && k == $past(k))
    else $error("line pixel counter broke a full line");

  a_shutter_sel : assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE9
    start |=> glob == $past(mode_trig))
    else $error("shutter mode does not match acquisition mode");

  a_roll_row : assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE10
    line_start && !glob && k < 13'(lines_l) |=> sens.row_rst && sens.rst_row == $past(k[11:0]))
    else $error("rolling row start missed its line slot");

  a_grr_read : assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE11
    in_read |=> sens.read_en && 13'(sens.read_row) + 13'(exp_eff) == $past(k))
    else $error("read row does not trail exposure by exposure rows");

  a_exp_min : assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE14
    scan |-> exp_eff >= `TES_EXP_MIN)
    else $error("exposure below the minimum row count");

  a_trig_drop : assert property (@(posedge ref_clk) disable iff (!rst_n) // see RULE15
    state == TES_SCAN && trig_evt && !scan_end |=> state == TES_SCAN)
    else $error("trigger during a frame was not dropped");

endmodule // tes_sequencer

// >>> sim/tes_far_side.sv
`timescale 1ns/10ps
module tes_far_side #(
  parameter int GAP   = 100,
  parameter int WID   = 520,
  parameter int FRAME = 100
) (
  input  wire logic ref_clk,
  input  wire logic trig_req,
  input  wire logic stb_req,
  input  wire logic exp_active,
  input  wire logic row_rst,
  input  wire logic reset_all,
  output logic      hw_trig,
  output logic      sens_strobe,
  output logic      flash
);
  int   since    = GAP;
  int   tlen     = 0;
  int   slen     = 0;
  int   open_cyc = 0;
  logic roll     = 1'b0;

  // pulses outlast the output delay lines, so no edge is overwritten
  assign hw_trig     = (tlen != 0);
  assign sens_strobe = (slen != 0);
  // global reset: flash fires with the exposure, no added delay
  // rolling: flash waits a frame so every row is open, ends with the first row
  assign flash       = roll ? (exp_active && open_cyc >= FRAME) : exp_active;

  // a request closer than the minimum trigger period is dropped, not queued
  always @(posedge ref_clk) begin
    since <= since + 1;
    if (trig_req && since >= GAP) begin
      tlen  <= WID;
      since <= 0;
    end else if (tlen > 0) begin
      tlen <= tlen - 1;
    end
    if (stb_req) begin
      slen <= WID;
    end else if (slen > 0) begin
      slen <= slen - 1;
    end
    if (row_rst) roll <= 1'b1;
    else if (reset_all) roll <= 1'b0;
    open_cyc <= exp_active ? open_cyc + 1 : 0;
  end
endmodule  // tes_far_side

// >>> sim/tes_sequencer_tb.sv
`timescale 1ns/10ps
`include "tes_map.svh"
module tes_sequencer_tb
  import tes_pkg::*;
;
  localparam int LP  = 200;
  localparam int DLY = 3;

  logic        ref_clk = 1'b0;
  logic        arst_n;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        hw_trig;
  logic        sens_strobe;
  tes_sens_t   sens;
  logic        strobe_out;
  logic        exp_active;
  logic        trig_req;
  logic        stb_req;
  int bad_count  = 0;
  int num_checks = 0;
  int cyc        = 0;
  int t_trig, t_ra, t_rr0, t_rr1, t_rd, t_stb, t_exp, t_ss, n_ra, n_rr, n_rd;
  int last_row, rd_col, rr_row;
  logic p_trig = 1'b0;
  logic p_stb  = 1'b0;
  logic p_exp  = 1'b0;
  logic p_ss   = 1'b0;

  tes_sequencer #(.LINE_PIX(LP)) dut (
    .ref_clk(ref_clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .hw_trig(hw_trig),
    .sens_strobe(sens_strobe), .sens(sens), .strobe_out(strobe_out),
    .exp_active(exp_active)
  );

  tes_far_side #(.GAP(1100)) far (
    .ref_clk(ref_clk), .trig_req(trig_req), .stb_req(stb_req),
    .exp_active(exp_active), .row_rst(sens.row_rst), .reset_all(sens.reset_all),
    .hw_trig(hw_trig),
    .sens_strobe(sens_strobe), .flash()
  );

  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;

  // ----------------------------------------------------------------
  // event monitor, sampled mid-cycle
  // ----------------------------------------------------------------
  always @(negedge ref_clk) begin
    if (hw_trig && !p_trig && t_trig < 0) t_trig = cyc;
    if (strobe_out && !p_stb && t_stb < 0) t_stb = cyc;
    if (exp_active && !p_exp && t_exp < 0) t_exp = cyc;
    if (sens_strobe && !p_ss && t_ss < 0) t_ss = cyc;
    if (sens.reset_all) begin
      n_ra++;
      if (t_ra < 0) t_ra = cyc;
    end
    if (sens.row_rst) begin
      n_rr++;
      rr_row = int'(sens.rst_row);
      if (t_rr0 < 0) t_rr0 = cyc;
      else if (t_rr1 < 0) t_rr1 = cyc;
    end
    if (sens.read_en) begin
      n_rd++;
      last_row = int'(sens.read_row);
      if (t_rd < 0) begin
        t_rd   = cyc;
        rd_col = int'(sens.col);
      end
    end
    p_trig = hw_trig;
    p_stb  = strobe_out;
    p_exp  = exp_active;
    p_ss   = sens_strobe;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic clr();
    {t_trig, t_ra, t_rr0, t_rr1, t_rd, t_stb, t_exp, t_ss} = {8{-32'sd1}};
    {n_ra, n_rr, n_rd} = '0;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    chk(name, rdata, exp);
  endtask

  task automatic pulse(input logic sel);
    @(posedge ref_clk);
    if (sel) trig_req <= 1'b1;
    else stb_req <= 1'b1;
    @(posedge ref_clk);
    trig_req <= 1'b0;
    stb_req  <= 1'b0;
  endtask

  task automatic wait_rd();
    for (int i = 0; i < 3000 && n_rd < 3 * LP; i++) @(posedge ref_clk);
  endtask

  task automatic close_out();
    if (bad_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    #100000;
    bad_count++;
    close_out();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {arst_n, wr, rd, trig_req, stb_req} = '0;
    addr  = 8'h00;
    wdata = 32'h0;
    clr();
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rd_chk("tdly", `TES_ADDR_TDLY, `TES_RST_TDLY);
    rd_chk("expo", `TES_ADDR_EXPO, `TES_RST_EXPO);
    rd_chk("lines", `TES_ADDR_LINES, `TES_RST_LINES);
    rd_chk("post", `TES_ADDR_POST, `TES_RST_POST);
    rd_chk("fcnt", `TES_ADDR_FCNT, 32'h0);
    rd_chk("unmapped", 8'h1C, 32'h0);
    wr_reg(`TES_ADDR_TDLY, DLY);
    wr_reg(`TES_ADDR_EXPO, 32'h2);
    wr_reg(`TES_ADDR_LINES, 32'h3);
    wr_reg(`TES_ADDR_POST, 32'hA);
    wr_reg(`TES_ADDR_CTRL, 32'h3);
    rd_chk("ctrl", `TES_ADDR_CTRL, 32'h3);
    repeat (10) @(posedge ref_clk);
    rd_chk("idle stat", `TES_ADDR_STAT, 32'h0);
    chk("idle reset", n_ra, 0);
    pulse(1'b1);
    repeat (20) @(posedge ref_clk);
    rd_chk("scan stat", `TES_ADDR_STAT, 32'hE);
    wr_reg(`TES_ADDR_CTRL, 32'h7);
    wait_rd();
    rd_chk("post stat", `TES_ADDR_STAT, 32'hF);
    wr_reg(`TES_ADDR_CTRL, 32'h7);
    repeat (700) @(posedge ref_clk);
    chk("trig delay", t_ra - t_trig, DLY + 3);
    chk("reset pulses", n_ra, 1);
    chk("read start", t_rd - t_ra, 2 * LP);
    chk("line pixels", n_rd, 3 * LP);
    chk("first col", rd_col, 0);
    chk("last row", last_row, 2);
    chk("trig strobe", t_stb - t_trig, `TES_TRG_STB_CYC);
    chk("exp active", t_exp - t_ra, `TES_EXP_ACT_CYC - 1);
    rd_chk("frames one", `TES_ADDR_FCNT, 32'h1);
    clr();
    pulse(1'b0);
    repeat (520) @(posedge ref_clk);
    chk("sens strobe", t_ss < 0 ? -1 : t_stb - t_ss, `TES_SNS_STB_CYC);
    wr_reg(`TES_ADDR_EXPO, 32'h0);
    wr_reg(`TES_ADDR_TDLY, 32'h0);
    clr();
    wr_reg(`TES_ADDR_CTRL, 32'h7);
    wait_rd();
    chk("min expo", t_rd - t_ra, LP);
    rd_chk("frames two", `TES_ADDR_FCNT, 32'h2);
    repeat (20) @(posedge ref_clk);
    clr();
    wr_reg(`TES_ADDR_CTRL, 32'h1);
    repeat (20) @(posedge ref_clk);
    rd_chk("roll stat", `TES_ADDR_STAT, 32'h6);
    wr_reg(`TES_ADDR_CTRL, 32'h0);
    wait_rd();
    chk("roll global", n_ra, 0);
    chk("roll rows", n_rr, 3);
    chk("roll lag", t_rr1 - t_rr0, LP);
    chk("roll last row", rr_row, 2);
    close_out();
  end
endmodule  // tes_sequencer_tb
